// file: verilog/gcs_pkg.sv
/*
  Constants, types and helpers shared by the glitchless clock switchover.
  Assumes a single 25 MHz system clock that samples both clock sources as data.
*/
// Summary of operation
// - Both clock inputs behave identically; either may serve as primary source.
// - Delay pin strapped to supply disables runt suppression; plain immediate multiplexer.
// - A collapsed selected input freezes the output at its last valid level.
// - Running clocks: pass current pulses, hold low on target pulses, then follow.
// - Current stuck high: hold high on target pulses, low on falls, then follow.
// - The stretched cycle has high and low phases above half a target period.
// - Current stuck low: hold low on target falling edges, then follow target.
// - Collapsed current clock: stuck-high or stuck-low handover by the latched level.
// - Floating, static or zero-swing input still yields a stable defined output.
// - A slowly degrading but toggling input is passed through without correction.
// - The asynchronous select is resynchronised, so stage counts may vary slightly.
// - Power-up reset holds the logic until the supply settles, then releases cleanly.
// - With runt suppression on, the handover lasts a set number of source edges, so its cycle count scales with the clocks.

package gcs_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int CLK_MHZ = 25;
  localparam int POR_HOLD_US = 100;
  localparam int POR_CYCLES = POR_HOLD_US * CLK_MHZ;
  localparam int POR_W = 12;

  // ==========================================================
  // Handover stage counts
  // ==========================================================
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] DRAIN_PULSES = 3'h2;
  localparam logic [CNT_W-1:0] STUCK_TARGET_PULSES = 3'h3;
  localparam logic [CNT_W-1:0] HIGH_HOLD_PULSES = 3'h2;
  localparam logic [CNT_W-1:0] LOW_HOLD_EDGES = 3'h2;
  localparam int HANDOVER_MAX_CYCLES = 17;

  // ==========================================================
  // Types
  // ==========================================================
  typedef struct packed {
    logic b;
    logic a;
  } gcs_pair_t;

  typedef enum logic [1:0] {
    ST_FOLLOW = 2'b00,
    ST_DRAIN = 2'b01,
    ST_HIGH_HOLD = 2'b10,
    ST_LOW_HOLD = 2'b11
  } gcs_state_t;

  // Same selection for both inputs keeps the two sources symmetric.
  function automatic logic gcs_pick(input gcs_pair_t p, input logic sel);
    gcs_pick = sel ? p.b : p.a;
  endfunction

endpackage

// file: verilog/gcs_edge_counter.sv
/*
  Small saturating edge counter used for each handover stage.
  Assumes the caller supplies a one-cycle step per counted input edge.
*/
`timescale 1ns/1ps
`default_nettype none

module gcs_edge_counter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic step,
  input wire logic [gcs_pkg::CNT_W-1:0] limit,
  output logic last,
  output logic done
);

  // ==========================================================
  // Count register
  // ==========================================================
  logic [gcs_pkg::CNT_W-1:0] count;
  logic [gcs_pkg::CNT_W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (clear) begin
      next_count = '0;
    end else if (step && !done) begin
      next_count = count + 3'h1;
    end
    last = (count == limit - 3'h1);
    done = (count >= limit);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule // gcs_edge_counter

`default_nettype wire

// file: verilog/gcs_switchover.sv
/*
  Glitchless two-input clock switchover with loss hold and power-up reset.
  Assumes both clock sources and their amplitude flags are sampled by clk,
  and that the sources are well below half the clk rate.
*/
`timescale 1ns/1ps
`default_nettype none

module gcs_switchover (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clockInputA,
  input wire logic clockInputB,
  input wire logic amplitudeOkA,
  input wire logic amplitudeOkB,
  input wire logic sourceSelect,
  input wire logic delayCapTiedHigh,
  input wire logic supplyAboveMin,
  output logic clockOut,
  output logic activeSource,
  output logic handoverBusy,
  output logic switchReady
);

  // ==========================================================
  // Power-up reset
  // ==========================================================
  localparam int POR_W_L = gcs_pkg::POR_W;
  localparam logic [POR_W_L-1:0] POR_END = POR_W_L'(gcs_pkg::POR_CYCLES);
  logic [POR_W_L-1:0] porCount;
  logic [POR_W_L-1:0] next_porCount;
  logic next_switchReady;
  logic bypass;
  logic next_bypass;

  always_comb begin
    next_porCount = porCount;
    next_switchReady = switchReady;
    next_bypass = bypass;
    if (!supplyAboveMin) begin
      next_porCount = '0;
      next_switchReady = 1'b0;
    end else if (!switchReady) begin
      next_porCount = porCount + 12'h001;
      if (porCount == POR_END - 12'h001) begin
        next_switchReady = 1'b1;
        // The strap is caught at release so it cannot change mid-operation.
        next_bypass = delayCapTiedHigh;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      porCount <= '0;
      switchReady <= 1'b0;
      bypass <= 1'b0;
    end else begin
      porCount <= next_porCount;
      switchReady <= next_switchReady;
      bypass <= next_bypass;
    end
  end

  // ==========================================================
  // Select synchroniser
  // ==========================================================
  logic selMeta;
  logic selSync;
  logic next_selMeta;
  logic next_selSync;

  always_comb begin
    next_selMeta = sourceSelect;
    next_selSync = selMeta;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      selMeta <= 1'b0;
      selSync <= 1'b0;
    end else begin
      selMeta <= next_selMeta;
      selSync <= next_selSync;
    end
  end

  // ==========================================================
  // Input samples and edge detection
  // ==========================================================
  gcs_pkg::gcs_pair_t level;
  gcs_pkg::gcs_pair_t okPair;
  gcs_pkg::gcs_pair_t prevLevel;
  gcs_pkg::gcs_pair_t next_prevLevel;

  always_comb begin
    level = '{b: clockInputB, a: clockInputA};
    okPair = '{b: amplitudeOkB, a: amplitudeOkA};
    next_prevLevel = level;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prevLevel <= '0;
    end else begin
      prevLevel <= next_prevLevel;
    end
  end

  logic curLevel;
  logic curValid;
  logic curFall;
  logic tgtLevel;
  logic tgtRise;
  logic tgtFall;

  always_comb begin
    // One pick function serves both roles, so neither input is favoured.
    curLevel = gcs_pkg::gcs_pick(level, activeSource);
    curValid = gcs_pkg::gcs_pick(okPair, activeSource);
    curFall = curValid && gcs_pkg::gcs_pick(prevLevel, activeSource) && !curLevel;
    tgtLevel = gcs_pkg::gcs_pick(level, !activeSource);
    tgtRise = tgtLevel && !gcs_pkg::gcs_pick(prevLevel, !activeSource);
    tgtFall = !tgtLevel && gcs_pkg::gcs_pick(prevLevel, !activeSource);
  end

  // ==========================================================
  // Stage counters
  // ==========================================================
  gcs_pkg::gcs_state_t state;
  gcs_pkg::gcs_state_t next_state;
  logic curStep;
  logic tgtStep;
  logic cntClear;
  logic curLast;
  logic tgtLast;
  logic tgtDone;
  logic [gcs_pkg::CNT_W-1:0] tgtLimit;

  always_comb begin
    cntClear = (next_state != state) || (state == gcs_pkg::ST_FOLLOW);
    curStep = (state == gcs_pkg::ST_DRAIN) && curFall;
    tgtStep = 1'b0;
    tgtLimit = gcs_pkg::STUCK_TARGET_PULSES;
    unique case (state)
      gcs_pkg::ST_FOLLOW: begin
        tgtStep = 1'b0;
      end
      gcs_pkg::ST_DRAIN: begin
        tgtStep = tgtRise;
      end
      gcs_pkg::ST_HIGH_HOLD: begin
        tgtStep = tgtRise;
        tgtLimit = gcs_pkg::HIGH_HOLD_PULSES;
      end
      gcs_pkg::ST_LOW_HOLD: begin
        tgtStep = tgtFall;
        tgtLimit = gcs_pkg::LOW_HOLD_EDGES;
      end
    endcase
  end

  // Counting current edges bounds the drain stage for a running source.
  gcs_edge_counter u_curCount (
    .clk(clk),
    .rst_n(rst_n),
    .clear(cntClear),
    .step(curStep),
    .limit(gcs_pkg::DRAIN_PULSES),
    .last(curLast),
    .done()
  );

  gcs_edge_counter u_tgtCount (
    .clk(clk),
    .rst_n(rst_n),
    .clear(cntClear),
    .step(tgtStep),
    .limit(tgtLimit),
    .last(tgtLast),
    .done(tgtDone)
  );

  // ==========================================================
  // Handover sequencer
  // ==========================================================
  logic lastLevel;
  logic next_lastLevel;
  logic next_clockOut;
  logic next_activeSource;
  logic next_handoverBusy;

  always_comb begin
    next_state = state;
    next_clockOut = clockOut;
    next_activeSource = activeSource;
    next_handoverBusy = handoverBusy;
    next_lastLevel = lastLevel;
    // A gradually weakening but toggling input still counts as valid.
    if (curValid) begin
      next_lastLevel = curLevel;
    end
    if (!switchReady) begin
      // Tracking the select here means release never starts a handover.
      next_state = gcs_pkg::ST_FOLLOW;
      next_clockOut = 1'b0;
      next_activeSource = selSync;
      next_handoverBusy = 1'b0;
      next_lastLevel = 1'b0;
    end else if (bypass) begin
      next_state = gcs_pkg::ST_FOLLOW;
      next_activeSource = selSync;
      next_handoverBusy = 1'b0;
      if (gcs_pkg::gcs_pick(okPair, selSync)) begin
        next_clockOut = gcs_pkg::gcs_pick(level, selSync);
      end else begin
        next_clockOut = lastLevel;
      end
    end else begin
      unique case (state)
        gcs_pkg::ST_FOLLOW: begin
          // A collapsed input never reaches the output, so no undefined level.
          next_clockOut = curValid ? curLevel : lastLevel;
          if (selSync != activeSource) begin
            next_handoverBusy = 1'b1;
            if (!curValid) begin
              next_clockOut = lastLevel;
              next_state = lastLevel ? gcs_pkg::ST_HIGH_HOLD
                                     : gcs_pkg::ST_LOW_HOLD;
            end else begin
              next_state = gcs_pkg::ST_DRAIN;
            end
          end
        end
        gcs_pkg::ST_DRAIN: begin
          next_clockOut = curValid ? curLevel : lastLevel;
          if (curFall && curLast) begin
            // Leaving on a falling edge means the output is already low.
            next_clockOut = 1'b0;
            next_state = gcs_pkg::ST_LOW_HOLD;
          end else if (!curValid || (tgtRise && tgtLast)) begin
            // Second current fall not seen within the target window: treat as stuck.
            next_clockOut = lastLevel;
            next_state = lastLevel ? gcs_pkg::ST_HIGH_HOLD
                                   : gcs_pkg::ST_LOW_HOLD;
          end
        end
        gcs_pkg::ST_HIGH_HOLD: begin
          next_clockOut = 1'b1;
          // Dropping only on a target fall after whole pulses keeps the
          // stretched high phase above half a target period.
          if (tgtFall && tgtDone) begin
            next_clockOut = 1'b0;
            next_state = gcs_pkg::ST_LOW_HOLD;
          end
        end
        gcs_pkg::ST_LOW_HOLD: begin
          next_clockOut = 1'b0;
          // Joining right after a target fall gives a full low phase.
          if (tgtFall && tgtLast) begin
            next_activeSource = !activeSource;
            next_handoverBusy = 1'b0;
            next_state = gcs_pkg::ST_FOLLOW;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= gcs_pkg::ST_FOLLOW;
      clockOut <= 1'b0;
      activeSource <= 1'b0;
      handoverBusy <= 1'b0;
      lastLevel <= 1'b0;
    end else begin
      state <= next_state;
      clockOut <= next_clockOut;
      activeSource <= next_activeSource;
      handoverBusy <= next_handoverBusy;
      lastLevel <= next_lastLevel;
    end
  end

endmodule // gcs_switchover

`default_nettype wire

// file: sim/gcs_switchover_asserts.sv
/*
  Assertions on the ports of the clock switchover, bound to every instance.
  Assumes the strap only changes while the block is held in reset.
*/
`timescale 1ns/1ps
`default_nettype none

module gcs_switchover_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clockInputA,
  input wire logic clockInputB,
  input wire logic amplitudeOkA,
  input wire logic amplitudeOkB,
  input wire logic sourceSelect,
  input wire logic delayCapTiedHigh,
  input wire logic supplyAboveMin,
  input wire logic clockOut,
  input wire logic activeSource,
  input wire logic handoverBusy,
  input wire logic switchReady
);
  localparam int BUSY_MAX = 250;
  logic selClk, selOk, prevOut;
  logic [7:0] runLen;
  logic [1:0] armed;
  assign selClk = activeSource ? clockInputB : clockInputA;
  assign selOk = activeSource ? amplitudeOkB : amplitudeOkA;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==================================
  // Phase width tracking
  // The first phase after ready or a loss may be cut short, so widths are
  // judged only after two clean output edges.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prevOut <= 1'b0;
      runLen <= 8'h0;
      armed <= 2'h0;
    end else begin
      prevOut <= clockOut;
      runLen <= (clockOut != prevOut) ? 8'h1 : runLen + {7'h0, runLen != 8'hff};
      if (!switchReady || delayCapTiedHigh || !selOk) begin
        armed <= 2'h0;
      end else if (clockOut != prevOut && armed != 2'h2) begin
        armed <= armed + 2'h1;
      end
    end
  end
  // ==================================
  // Assertions
  chk_quiet_unready: assert property (!switchReady |-> !clockOut && !handoverBusy)
    else $error("output active before ready");
  chk_busy_on_change: assert property ($rose(handoverBusy) |-> activeSource != sourceSelect)
    else $error("handover without a select change");
  chk_busy_bounded: assert property ($rose(handoverBusy) |-> ##[1:BUSY_MAX] !handoverBusy)
    else $error("handover too long");
  chk_lands_low: assert property ($fell(handoverBusy) && switchReady |->
    activeSource == sourceSelect && !$past(clockOut))
    else $error("handover landed wrongly");
  chk_follow_selected: assert property (switchReady && $past(switchReady) &&
    !handoverBusy && !$past(handoverBusy) && $stable(activeSource) && $past(selOk) &&
    $past(selOk, 2) |-> clockOut == $past(selClk))
    else $error("output not following source");
  chk_loss_freezes: assert property (switchReady && !handoverBusy &&
    !$past(handoverBusy) && $stable(activeSource) && !$past(selOk) |-> $stable(clockOut))
    else $error("output moved during loss");
  chk_no_runt: assert property (clockOut != prevOut && armed == 2'h2 |-> runLen >= 8'h3)
    else $error("short output phase");
  chk_bypass_no_busy: assert property (delayCapTiedHigh && switchReady |-> !handoverBusy)
    else $error("handover in plain mux mode");
endmodule // gcs_switchover_checker

bind gcs_switchover gcs_switchover_checker u_checker (.clk, .rst_n, .clockInputA,
  .clockInputB, .amplitudeOkA, .amplitudeOkB, .sourceSelect, .delayCapTiedHigh,
  .supplyAboveMin, .clockOut, .activeSource, .handoverBusy, .switchReady);

`default_nettype wire

// file: sim/gcs_source_model.sv
/*
  Behavioural model of one redundant clock source.
  Assumes the bench clock is much faster than the source.
*/
`timescale 1ns/1ps
`default_nettype none

module gcs_source_model #(
  parameter logic [3:0] HALF = 4'h4
) (
  input wire logic clk,
  input wire logic stuck,
  input wire logic stuckLevel,
  input wire logic ampOk,
  output logic clockLine
);
  logic [3:0] phaseCnt = 4'h0;
  logic level = 1'b0;
  logic noise = 1'b0;
  // ==================================
  // Source clock
  // A stopping source parks only at the asked level, so it leaves no short phase.
  always @(posedge clk) begin
    noise <= ~noise;
    if (!(stuck && level == stuckLevel)) begin
      phaseCnt <= (phaseCnt == HALF - 4'h1) ? 4'h0 : phaseCnt + 4'h1;
      if (phaseCnt == HALF - 4'h1) begin
        level <= ~level;
      end
    end
  end
  // A collapsed source has no defined level, so the line shows a toggling pattern.
  assign clockLine = ampOk ? level : noise;
endmodule // gcs_source_model

`default_nettype wire

// file: sim/tb_top.sv
/*
  Self-checking bench for the clock switchover with two source models.
  Assumes the checker file is compiled alongside and binds itself.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clk, clockInputA, clockInputB, clockOut, activeSource, handoverBusy, switchReady;
  logic rst_n = 1'b0;
  logic amplitudeOkA = 1'b1;
  logic amplitudeOkB = 1'b1;
  logic sourceSelect = 1'b0;
  logic delayCapTiedHigh = 1'b0;
  logic supplyAboveMin = 1'b0;
  logic stuckA = 1'b0;
  logic stuckB = 1'b0;
  logic stuckLevel = 1'b0;
  int failures = 0;
  int checkCount = 0;
  // ==================================
  // Sources and device
  // Half periods of 4 and 5 cycles keep the source ratio at 1.25 to 1.
  gcs_source_model #(.HALF(4'h4)) srcA (.clk, .stuck(stuckA), .stuckLevel,
    .ampOk(amplitudeOkA), .clockLine(clockInputA));
  gcs_source_model #(.HALF(4'h5)) srcB (.clk, .stuck(stuckB), .stuckLevel,
    .ampOk(amplitudeOkB), .clockLine(clockInputB));
  gcs_switchover DUT (.clk, .rst_n, .clockInputA, .clockInputB, .amplitudeOkA,
    .amplitudeOkB, .sourceSelect, .delayCapTiedHigh, .supplyAboveMin, .clockOut,
    .activeSource, .handoverBusy, .switchReady);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ==================================
  // Shared tasks
  task automatic check(input string what, input logic seen, input logic exp);
    checkCount++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_busy(input logic lvl, output int took);
    took = 0;
    while (handoverBusy !== lvl && took < 300) begin
      @(posedge clk);
      #1 took++;
    end
  endtask
  task automatic follow(input logic src);
    logic prev;
    repeat (3) @(posedge clk);
    repeat (20) begin
      #1 prev = src ? clockInputB : clockInputA;
      @(posedge clk);
      #1 check("follow", clockOut, prev);
    end
  endtask
  // ==================================
  // Scenarios
  // The supply rises only after reset is released, so the hold must count from its rise.
  task automatic power_up(input logic strap);
    @(posedge clk);
    rst_n <= 1'b0;
    delayCapTiedHigh <= strap;
    sourceSelect <= 1'b0;
    supplyAboveMin <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    supplyAboveMin <= 1'b1;
    repeat (2400) @(posedge clk);
    #1 check("ready early", switchReady, 1'b0);
    repeat (110) @(posedge clk);
    #1 check("ready", switchReady, 1'b1);
  endtask
  task automatic switch_case(input logic to);
    int took;
    @(posedge clk);
    sourceSelect <= to;
    wait_busy(1'b1, took);
    check("busy after select", took <= 4, 1'b1);
    wait_busy(1'b0, took);
    check("handover time", took < 200, 1'b1);
    check("new source", activeSource, to);
    follow(to);
  endtask
  task automatic fail_case(input logic to, input logic lvl, input logic lost);
    int took;
    @(posedge clk);
    stuckLevel <= lvl;
    if (to) stuckA <= 1'b1;
    else stuckB <= 1'b1;
    repeat (12) @(posedge clk);
    if (lost && to) amplitudeOkA <= 1'b0;
    if (lost && !to) amplitudeOkB <= 1'b0;
    repeat (6) @(posedge clk);
    #1 check("parked level", clockOut, lvl);
    @(posedge clk);
    sourceSelect <= to;
    wait_busy(1'b1, took);
    repeat (4) @(posedge clk);
    #1 check("held level", clockOut, lvl);
    wait_busy(1'b0, took);
    check("stuck handover time", took < 200, 1'b1);
    check("stuck new source", activeSource, to);
    @(posedge clk);
    {stuckA, stuckB, amplitudeOkA, amplitudeOkB} <= 4'h3;
    follow(to);
  endtask
  task automatic bypass_case();
    power_up(1'b1);
    @(posedge clk);
    sourceSelect <= 1'b1;
    repeat (4) @(posedge clk);
    #1 check("bypass source", activeSource, 1'b1);
    check("bypass busy", handoverBusy, 1'b0);
    follow(1'b1);
  endtask
  // ==================================
  // Main sequence and watchdog
  initial begin
    power_up(1'b0);
    switch_case(1'b1);
    switch_case(1'b0);
    fail_case(1'b1, 1'b1, 1'b0);
    fail_case(1'b0, 1'b0, 1'b0);
    fail_case(1'b1, 1'b1, 1'b1);
    fail_case(1'b0, 1'b0, 1'b1);
    bypass_case();
    complete_run();
  end
  // The whole run needs under ten thousand cycles, so this limit means a hang.
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    complete_run();
  end
endmodule // tb_top

`default_nettype wire
